// ---- mts_defines.vh ----
`ifndef MTS_DEFINES_VH
`define MTS_DEFINES_VH
// register byte offsets
`define MTS_OFF_CTRL 8'h00
`define MTS_OFF_MODE 8'h04
`define MTS_OFF_SAMPLES 8'h08
`define MTS_OFF_TRIGCNT 8'h0C
`define MTS_OFF_DELAY 8'h10
`define MTS_OFF_STATUS 8'h14
// control register command bits (write one to act)
`define MTS_CTRL_ARM 0
`define MTS_CTRL_BUS_TRIG 1
`define MTS_CTRL_DEV_CLEAR 2
`define MTS_CTRL_CONFIGURE 3
`define MTS_CTRL_IF_RESET 4
`define MTS_CTRL_CLR_IGNORED 5
// mode register fields
`define MTS_MODE_REMOTE 0
`define MTS_MODE_SRC_LSB 1
`define MTS_MODE_SRC_MSB 2
`define MTS_MODE_LOCAL_SINGLE 3
// remote trigger source encodings
`define MTS_SRC_IMM 2'h0
`define MTS_SRC_EXT 2'h1
`define MTS_SRC_BUS 2'h2
// count and delay fields
`define MTS_INF_BIT 16
`define MTS_AUTO_BIT 16
`define MTS_COUNT_MIN 16'h0001
`define MTS_COUNT_MAX 16'hC350
`define MTS_DELAY_MAX 12'hE10
// reset values
`define MTS_RST_COUNT 16'h0001
`define MTS_RST_DELAY 12'h000
`define MTS_RST_SRC 2'h0
// timing: clock rate and one second of delay
`define MTS_CLK_HZ 10000000
`define MTS_SEC_PER_UNIT 1
// automatic delay, 1.5 ms at the clock rate
`define MTS_AUTO_DELAY_US 1500
`endif

// ---- mts_trigger_sequencer.v ----
`timescale 1ns/1ps
`include "mts_defines.vh"
module mts_trigger_sequencer #(
    parameter CYC_PER_SEC = `MTS_CLK_HZ * `MTS_SEC_PER_UNIT,
    parameter AUTO_DELAY_CYC = (`MTS_CLK_HZ / 1000000) * `MTS_AUTO_DELAY_US
) (
    input wire clk_sys, // 10 MHz system clock
    input wire resetn, // synchronous reset, active low
    input wire psel, // apb select
    input wire penable, // apb access phase
    input wire pwrite, // apb direction
    input wire [7:0] paddr, // apb byte address
    input wire [31:0] pwdata, // apb write data
    output reg [31:0] prdata, // apb read data
    output reg pready, // apb ready
    output reg pslverr, // apb error on unmapped address
    input wire ext_trig_n, // external trigger pin, low-true pulse
    input wire single_key, // front-panel single key, high while pressed
    input wire group_trigger, // group execute trigger pulse from interface
    input wire meas_done, // engine finished one reading, pulse
    output reg meas_start, // start one reading, pulse
    output reg waiting, // armed and awaiting single or external trigger
    output reg measuring // a trigger is being serviced
);
    localparam ST_IDLE = 4'h1;
    localparam ST_WAIT = 4'h2;
    localparam ST_DELAY = 4'h4;
    localparam ST_MEAS = 4'h8;

    reg [3:0] state;
    reg remote;
    reg [1:0] src;
    reg local_single;
    reg [15:0] samples;
    reg [15:0] trig_count;
    reg trig_inf;
    reg [11:0] delay_sec;
    reg delay_auto;
    reg ignored;
    reg ext_pend;
    reg [15:0] sample_done;
    reg [15:0] trig_done;
    reg [11:0] sec_left;
    reg [23:0] cyc_cnt;
    reg issued;
    reg remote_q;
    reg [2:0] ext_sync;
    reg [2:0] key_sync;

    wire apb_done;
    wire wr;
    wire [31:0] wdat;
    wire cmd_arm;
    wire cmd_bus;
    wire cmd_clear;
    wire cmd_config;
    wire cmd_ifreset;
    wire cmd_clr_ign;
    wire ext_edge;
    wire key_edge;
    wire bus_trig;
    wire ext_allowed;
    wire in_wait;
    wire ext_take;
    wire trig_now;
    wire delay_over;
    wire last_sample;
    wire last_trigger;
    wire abort;
    wire ign_event;
    wire [15:0] wr_count;
    wire [11:0] wr_delay;
    wire [23:0] sec_last;
    wire [23:0] auto_last;
    reg [31:0] next_prdata;
    reg next_slverr;

    // apb: one wait state, writes land at the completing edge
    assign apb_done = psel & penable & pready;
    assign wr = apb_done & pwrite;
    assign wdat = pwdata;
    assign cmd_arm = wr & (paddr == `MTS_OFF_CTRL) & wdat[`MTS_CTRL_ARM];
    assign cmd_bus = wr & (paddr == `MTS_OFF_CTRL) & wdat[`MTS_CTRL_BUS_TRIG];
    assign cmd_clear = wr & (paddr == `MTS_OFF_CTRL) & wdat[`MTS_CTRL_DEV_CLEAR];
    assign cmd_config = wr & (paddr == `MTS_OFF_CTRL) & wdat[`MTS_CTRL_CONFIGURE];
    assign cmd_ifreset = wr & (paddr == `MTS_OFF_CTRL) & wdat[`MTS_CTRL_IF_RESET];
    assign cmd_clr_ign = wr & (paddr == `MTS_OFF_CTRL) & wdat[`MTS_CTRL_CLR_IGNORED];

    // out-of-range counts are clamped rather than refused
    assign wr_count = (wdat[15:0] < `MTS_COUNT_MIN) ? `MTS_COUNT_MIN :
                      (wdat[15:0] > `MTS_COUNT_MAX) ? `MTS_COUNT_MAX : wdat[15:0];
    assign wr_delay = (wdat[15:0] > {4'h0, `MTS_DELAY_MAX}) ? `MTS_DELAY_MAX : wdat[11:0];

    // pins pass three flops; only the second and third stages are looked at
    always @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            ext_sync <= 3'h7;
            key_sync <= 3'h0;
        end
        else
        begin
            ext_sync <= {ext_sync[1:0], ext_trig_n};
            key_sync <= {key_sync[1:0], single_key};
        end
    end

    assign ext_edge = ext_sync[2] & ~ext_sync[1];
    assign key_edge = ~key_sync[2] & key_sync[1] & ~remote;
    assign bus_trig = remote & (src == `MTS_SRC_BUS) & (cmd_bus | group_trigger);
    assign ext_allowed = remote ? (src == `MTS_SRC_EXT) : local_single;
    assign in_wait = (state == ST_WAIT);
    // the first external edge while busy is held, not reported as ignored
    assign ext_take = ext_allowed & (ext_edge | ext_pend) & in_wait;

    // trigger present in the wait state
    assign trig_now = in_wait & (remote ?
        ((src == `MTS_SRC_IMM) | bus_trig | ext_take) :
        ((~local_single) | (local_single & key_edge) | ext_take));

    // trigger events that find the sequencer unready
    assign ign_event = (bus_trig & ~in_wait) |
                       (key_edge & local_single & ~in_wait) |
                       (ext_allowed & ext_edge & ~in_wait & (ext_pend | (state == ST_IDLE)));

    // last counts of one second and of the automatic delay, cut to the counter's width
    assign sec_last = CYC_PER_SEC[23:0] - 24'h000001;
    assign auto_last = AUTO_DELAY_CYC[23:0] - 24'h000001;
    assign delay_over = delay_auto ? (cyc_cnt >= auto_last) :
                        ((sec_left == 12'h000) | ((sec_left == 12'h001) & (cyc_cnt >= sec_last)));
    assign last_sample = (sample_done + 16'h0001 >= samples);
    assign last_trigger = remote & ~trig_inf & (trig_done + 16'h0001 >= trig_count);
    // leaving or entering remote drops any run, like a clear
    assign abort = cmd_clear | (remote != remote_q);

    // configuration registers; device clear leaves these alone
    always @(posedge clk_sys)
    begin
        if (!resetn || cmd_ifreset)
        begin
            remote <= 1'b0;
            src <= `MTS_RST_SRC;
            local_single <= 1'b0;
            samples <= `MTS_RST_COUNT;
            trig_count <= `MTS_RST_COUNT;
            trig_inf <= 1'b0;
            delay_sec <= `MTS_RST_DELAY;
            delay_auto <= 1'b1;
        end
        else if (cmd_config)
        begin
            src <= `MTS_SRC_IMM;
            samples <= `MTS_COUNT_MIN;
            trig_count <= `MTS_COUNT_MIN;
            trig_inf <= 1'b0;
            delay_auto <= 1'b1;
        end
        else if (wr)
        begin
            case (paddr)
                `MTS_OFF_MODE:
                begin
                    remote <= wdat[`MTS_MODE_REMOTE];
                    src <= (wdat[`MTS_MODE_SRC_MSB:`MTS_MODE_SRC_LSB] > `MTS_SRC_BUS) ?
                           src : wdat[`MTS_MODE_SRC_MSB:`MTS_MODE_SRC_LSB];
                    local_single <= wdat[`MTS_MODE_LOCAL_SINGLE];
                end
                `MTS_OFF_SAMPLES: samples <= wr_count;
                `MTS_OFF_TRIGCNT:
                begin
                    trig_count <= wr_count;
                    trig_inf <= wdat[`MTS_INF_BIT];
                end
                `MTS_OFF_DELAY:
                begin
                    delay_sec <= wr_delay;
                    delay_auto <= wdat[`MTS_AUTO_BIT];
                end
                default: ;
            endcase
        end
    end

    // sequencer state machine
    always @(posedge clk_sys)
    begin
        if (!resetn || cmd_ifreset)
        begin
            state <= ST_IDLE;
            remote_q <= 1'b0;
            sample_done <= 16'h0000;
            trig_done <= 16'h0000;
            sec_left <= 12'h000;
            cyc_cnt <= 24'h000000;
            issued <= 1'b0;
            meas_start <= 1'b0;
        end
        else
        begin
            remote_q <= remote;
            meas_start <= 1'b0;
            if (abort)
            begin
                state <= ST_IDLE;
                issued <= 1'b0;
            end
            else
            begin
                case (state)
                    ST_IDLE:
                    begin
                        sample_done <= 16'h0000;
                        trig_done <= 16'h0000;
                        // remote waits for an arm command; local control re-arms at once
                        if (!remote || cmd_arm)
                            state <= ST_WAIT;
                    end
                    ST_WAIT:
                    begin
                        sample_done <= 16'h0000;
                        // the first trigger found present starts the delay of the burst
                        if (trig_now)
                        begin
                            state <= ST_DELAY;
                            sec_left <= delay_sec;
                            cyc_cnt <= 24'h000000;
                        end
                    end
                    ST_DELAY:
                    begin
                        if (delay_over)
                        begin
                            state <= ST_MEAS;
                            meas_start <= 1'b1;
                            issued <= 1'b1;
                        end
                        // whole seconds are counted down so the cycle counter stays 24 bits wide
                        else if (!delay_auto && cyc_cnt >= sec_last)
                        begin
                            cyc_cnt <= 24'h000000;
                            sec_left <= sec_left - 12'h001;
                        end
                        else
                            cyc_cnt <= cyc_cnt + 24'h000001;
                    end
                    ST_MEAS:
                    begin
                        if (meas_done && issued)
                        begin
                            issued <= 1'b0;
                            if (!last_sample)
                            begin
                                sample_done <= sample_done + 16'h0001;
                                state <= ST_DELAY;
                                sec_left <= delay_sec;
                                cyc_cnt <= 24'h000000;
                            end
                            else if (last_trigger)
                                state <= ST_IDLE;
                            else
                            begin
                                // infinite runs saturate the counter instead of wrapping
                                if (trig_done != 16'hFFFF)
                                    trig_done <= trig_done + 16'h0001;
                                state <= ST_WAIT;
                            end
                        end
                    end
                    default: state <= ST_IDLE;
                endcase
            end
        end
    end

    // external buffer and sticky ignored flag; on the flag a set beats a clear, on the buffer a clear wins
    always @(posedge clk_sys)
    begin
        if (!resetn || cmd_ifreset)
        begin
            ext_pend <= 1'b0;
            ignored <= 1'b0;
        end
        else
        begin
            // only one edge is held; a second one while busy counts as ignored
            if (abort || !ext_allowed)
                ext_pend <= 1'b0;
            else if (ext_take)
                ext_pend <= 1'b0;
            else if (ext_edge && (state == ST_DELAY || state == ST_MEAS))
                ext_pend <= 1'b1;
            if (ign_event)
                ignored <= 1'b1;
            else if (cmd_clr_ign)
                ignored <= 1'b0;
        end
    end

    // indicators, registered
    always @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            waiting <= 1'b0;
            measuring <= 1'b0;
        end
        else
        begin
            waiting <= in_wait & ~abort & (remote ? (src == `MTS_SRC_EXT) : local_single);
            measuring <= (state == ST_DELAY) | (state == ST_MEAS);
        end
    end

    // read mux
    always @*
    begin
        next_prdata = 32'h00000000;
        next_slverr = 1'b0;
        case (paddr)
            `MTS_OFF_CTRL: next_prdata = 32'h00000000;
            `MTS_OFF_MODE: next_prdata = {28'h0000000, local_single, src, remote};
            `MTS_OFF_SAMPLES: next_prdata = {16'h0000, samples};
            `MTS_OFF_TRIGCNT: next_prdata = {15'h0000, trig_inf, trig_count};
            `MTS_OFF_DELAY: next_prdata = {15'h0000, delay_auto, 4'h0, delay_sec};
            `MTS_OFF_STATUS: next_prdata = {trig_done, 9'h000, ext_pend, ignored, waiting, state};
            default: next_slverr = 1'b1;
        endcase
    end

    // apb answer one cycle into the access phase
    always @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end
        else
        begin
            pready <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & next_slverr;
            prdata <= (psel & penable & ~pready & ~pwrite) ? next_prdata : 32'h00000000;
        end
    end
endmodule

// ---- mts_trigger_sequencer_chk.sv ----
`timescale 1ns/1ps
`include "mts_defines.vh"
module mts_trigger_sequencer_chk (
    input wire clk_sys, // system clock
    input wire resetn, // sync reset, active low
    input wire psel, // apb select
    input wire penable, // apb access phase
    input wire pwrite, // apb direction
    input wire [7:0] paddr, // apb address
    input wire [31:0] pwdata, // apb write data
    input wire pready, // apb ready
    input wire pslverr, // apb error
    input wire ext_trig_n, // external trigger pin
    input wire meas_done, // reading finished
    input wire meas_start, // reading start
    input wire waiting, // armed indicator
    input wire measuring // trigger in service
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!resetn);
    // a device clear taken on the bus
    wire clr_hit = psel && penable && pready && pwrite && paddr == `MTS_OFF_CTRL && pwdata[`MTS_CTRL_DEV_CLEAR];
    a_ready_timing: assert property (psel && !penable |=> ##1 pready)
        else $error("ready not in second access cycle");
    a_ready_once: assert property (pready |=> !pready)
        else $error("ready held too long");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    a_start_pulse: assert property (meas_start |=> !meas_start)
        else $error("start longer than one cycle");
    a_start_busy: assert property (meas_start |-> ##[0:1] measuring)
        else $error("start outside a trigger");
    a_done_gap: assert property (meas_done && measuring |=> !meas_start)
        else $error("no delay before next reading");
    a_clear_idle: assert property (clr_hit |-> ##[1:3] !measuring)
        else $error("clear did not halt");
    a_ext_fires: assert property (waiting && $fell(ext_trig_n) |-> ##[1:8] !waiting)
        else $error("external pulse not taken");
    c_start: cover property (meas_start);
    c_err: cover property (pslverr);
    c_ext: cover property (waiting && $fell(ext_trig_n));
endmodule
bind mts_trigger_sequencer mts_trigger_sequencer_chk chk_i (.clk_sys(clk_sys), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .ext_trig_n(ext_trig_n), .meas_done(meas_done), .meas_start(meas_start), .waiting(waiting),
    .measuring(measuring));

// ---- mts_engine_model.sv ----
`timescale 1ns/1ps
module mts_engine_model (
    input wire logic clk_sys, // system clock
    input wire logic resetn, // sync reset, active low
    input wire logic meas_start, // start one reading
    input wire logic [31:0] lat, // cycles a reading takes
    output logic meas_done, // reading finished pulse
    output int nreads // readings started
);
    int cnt;
    // a new start restarts the count; an aborted reading still reports done unless a new start comes first
    always @(posedge clk_sys)
    begin
        meas_done <= 1'b0;
        if (!resetn)
        begin
            cnt <= 0;
            nreads <= 0;
        end
        else if (meas_start)
        begin
            nreads <= nreads + 1;
            cnt <= lat;
        end
        else if (cnt > 0)
        begin
            cnt <= cnt - 1;
            meas_done <= (cnt == 1);
        end
    end
endmodule

// ---- measurement_trigger_sequencer_bench.sv ----
`timescale 1ns/1ps
`include "mts_defines.vh"
module measurement_trigger_sequencer_bench;
    logic clk_sys = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic ext_trig_n = 1, single_key = 0, group_trigger = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    wire [31:0] prdata;
    wire pready, pslverr, meas_done, meas_start, waiting, measuring;
    int mismatches = 0, cmp_count = 0, lat = 4, nreads;
    // short seconds and auto delay keep the run brief
    mts_trigger_sequencer #(.CYC_PER_SEC(20), .AUTO_DELAY_CYC(3)) uut (.clk_sys(clk_sys), .resetn(resetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ext_trig_n(ext_trig_n), .single_key(single_key),
        .group_trigger(group_trigger), .meas_done(meas_done), .meas_start(meas_start), .waiting(waiting),
        .measuring(measuring));
    mts_engine_model eng (.clk_sys(clk_sys), .resetn(resetn), .meas_start(meas_start), .lat(lat),
        .meas_done(meas_done), .nreads(nreads));
    always #50 clk_sys = ~clk_sys;
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e)
        begin
            mismatches++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    // request held until pready is sampled high
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask
    task rdchk(input string n, input logic [7:0] a, input logic [31:0] x);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk(n, x, r);
    endtask
    // status low bits: state, waiting, ignored, pending
    task stat(input string n, input logic [6:0] x);
        logic [31:0] r;
        logic e;
        apb(1'b0, `MTS_OFF_STATUS, 32'h0, r, e);
        chk(n, {25'h0, x}, {25'h0, r[6:0]});
    endtask
    task cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task ext_pulse;
        @(posedge clk_sys);
        ext_trig_n <= 1'b0;
        cyc(3);
        ext_trig_n <= 1'b1;
    endtask
    task key_press;
        @(posedge clk_sys);
        single_key <= 1'b1;
        cyc(3);
        single_key <= 1'b0;
    endtask
    task gtrig;
        @(posedge clk_sys);
        group_trigger <= 1'b1;
        @(posedge clk_sys);
        group_trigger <= 1'b0;
    endtask
    task wait_idle;
        logic [31:0] r;
        logic e;
        for (int i = 0; i < 100; i++)
        begin
            apb(1'b0, `MTS_OFF_STATUS, 32'h0, r, e);
            if (r[3:0] === 4'h1)
                break;
        end
        chk("idle", 32'h1, {28'h0, r[3:0]});
    endtask
    task t_defaults;
        logic [31:0] r;
        logic e;
        rdchk("mode", `MTS_OFF_MODE, 32'h0);
        rdchk("samples", `MTS_OFF_SAMPLES, 32'h1);
        rdchk("trigcnt", `MTS_OFF_TRIGCNT, 32'h1);
        rdchk("delay", `MTS_OFF_DELAY, 32'h10000);
        apb(1'b0, 8'h18, 32'h0, r, e);
        chk("unmapped", 32'h1, {31'h0, e});
        cyc(40);
        chk("auto run", 32'h1, 32'(nreads >= 3));
    endtask
    task t_remote;
        int n0;
        wr(`MTS_OFF_MODE, 32'h1);
        cyc(10);
        wr(`MTS_OFF_SAMPLES, 32'h3);
        wr(`MTS_OFF_TRIGCNT, 32'h2);
        wr(`MTS_OFF_DELAY, 32'h0);
        n0 = nreads;
        wr(`MTS_OFF_CTRL, 32'h1);
        wait_idle();
        chk("readings", 32'(n0 + 6), 32'(nreads));
    endtask
    task t_bus;
        int n0;
        wr(`MTS_OFF_MODE, 32'h5);
        wr(`MTS_OFF_TRIGCNT, 32'h1);
        wr(`MTS_OFF_SAMPLES, 32'h1);
        n0 = nreads;
        wr(`MTS_OFF_CTRL, 32'h1);
        cyc(20);
        stat("bus armed", 7'h02);
        wr(`MTS_OFF_CTRL, 32'h2);
        wait_idle();
        gtrig();
        stat("idle ignored", 7'h21);
        wr(`MTS_OFF_CTRL, 32'h20);
        wr(`MTS_OFF_CTRL, 32'h1);
        cyc(5);
        gtrig();
        wait_idle();
        chk("bus reads", 32'(n0 + 2), 32'(nreads));
    endtask
    task t_ext;
        int n0;
        lat = 30;
        wr(`MTS_OFF_MODE, 32'h3);
        wr(`MTS_OFF_TRIGCNT, 32'h2);
        n0 = nreads;
        wr(`MTS_OFF_CTRL, 32'h1);
        cyc(3);
        stat("ext wait", 7'h12);
        ext_pulse();
        cyc(8);
        ext_pulse();
        wait_idle();
        chk("ext reads", 32'(n0 + 2), 32'(nreads));
        stat("buffered", 7'h01);
        ext_pulse();
        cyc(5);
        stat("ext ignored", 7'h21);
        wr(`MTS_OFF_CTRL, 32'h20);
        lat = 4;
    endtask
    task t_clear;
        int n0;
        wr(`MTS_OFF_MODE, 32'h1);
        wr(`MTS_OFF_SAMPLES, 32'h2);
        wr(`MTS_OFF_TRIGCNT, 32'h10007);
        n0 = nreads;
        wr(`MTS_OFF_CTRL, 32'h1);
        cyc(300);
        chk("infinite", 32'h1, 32'(nreads - n0 > 14));
        wr(`MTS_OFF_CTRL, 32'h4);
        stat("cleared", 7'h01);
        n0 = nreads;
        cyc(50);
        chk("halted", 32'(n0), 32'(nreads));
        rdchk("keep samples", `MTS_OFF_SAMPLES, 32'h2);
        rdchk("keep count", `MTS_OFF_TRIGCNT, 32'h10007);
        rdchk("keep delay", `MTS_OFF_DELAY, 32'h0);
        wr(`MTS_OFF_MODE, 32'h5);
        wr(`MTS_OFF_CTRL, 32'h8);
        rdchk("cfg mode", `MTS_OFF_MODE, 32'h1);
        rdchk("cfg samples", `MTS_OFF_SAMPLES, 32'h1);
        rdchk("cfg count", `MTS_OFF_TRIGCNT, 32'h1);
    endtask
    task t_local;
        int n0;
        wr(`MTS_OFF_MODE, 32'h8);
        cyc(5);
        stat("local wait", 7'h12);
        n0 = nreads;
        key_press();
        cyc(30);
        ext_pulse();
        cyc(30);
        chk("local reads", 32'(n0 + 2), 32'(nreads));
        wr(`MTS_OFF_MODE, 32'h3);
        wr(`MTS_OFF_CTRL, 32'h1);
        cyc(3);
        n0 = nreads;
        key_press();
        cyc(20);
        chk("remote key", 32'(n0), 32'(nreads));
    endtask
    // clamping of out-of-range values, then the interface reset restores defaults
    task t_ifreset;
        wr(`MTS_OFF_SAMPLES, 32'h0);
        rdchk("samples low", `MTS_OFF_SAMPLES, 32'h1);
        wr(`MTS_OFF_SAMPLES, 32'hFFFF);
        rdchk("samples high", `MTS_OFF_SAMPLES, 32'hC350);
        wr(`MTS_OFF_TRIGCNT, 32'h1FFFF);
        rdchk("count high", `MTS_OFF_TRIGCNT, 32'h1C350);
        wr(`MTS_OFF_DELAY, 32'hFFFF);
        rdchk("delay high", `MTS_OFF_DELAY, 32'hE10);
        wr(`MTS_OFF_MODE, 32'h5);
        wr(`MTS_OFF_CTRL, 32'h10);
        rdchk("reset mode", `MTS_OFF_MODE, 32'h0);
        rdchk("reset samples", `MTS_OFF_SAMPLES, 32'h1);
        rdchk("reset count", `MTS_OFF_TRIGCNT, 32'h1);
        rdchk("reset delay", `MTS_OFF_DELAY, 32'h10000);
    endtask
    // two seconds of 20 cycles before each of two readings
    task t_delay;
        int n0;
        wr(`MTS_OFF_MODE, 32'h1);
        wr(`MTS_OFF_SAMPLES, 32'h2);
        wr(`MTS_OFF_DELAY, 32'h2);
        n0 = nreads;
        wr(`MTS_OFF_CTRL, 32'h1);
        cyc(30);
        chk("delay first", 32'(n0), 32'(nreads));
        cyc(20);
        chk("first reading", 32'(n0 + 1), 32'(nreads));
        cyc(30);
        chk("delay second", 32'(n0 + 1), 32'(nreads));
        cyc(20);
        chk("second reading", 32'(n0 + 2), 32'(nreads));
        wait_idle();
    endtask
    task results;
        $display("Comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // main sequence after a five cycle reset
    initial
    begin
        repeat (5) @(posedge clk_sys);
        resetn <= 1'b1;
        t_defaults();
        t_remote();
        t_bus();
        t_ext();
        t_clear();
        t_local();
        t_ifreset();
        t_delay();
        results();
    end
    // the run needs about a thousand cycles; cut a hang at twenty thousand
    initial
    begin
        #2000000;
        mismatches++;
        results();
    end
endmodule
